// >>> design/regmap_pkg.sv
// Shared constants of the paged register bank and its host controller
package regmap_pkg;

   // ----------------------------------------------------------------
   // Paged register space
   // ----------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int OFF_W = 8;
   localparam int PAGE_W = 8;
   localparam int ADDR_W = 16;
   localparam logic [PAGE_W-1:0] PAGE_RESET = 8'h00;
   localparam logic [OFF_W-1:0] PAGE_SEL_OFF = 8'h01;
   localparam logic [OFF_W-1:0] READY_OFF = 8'hfe;
   localparam logic [DATA_W-1:0] READY_VAL = 8'h0f;
   localparam logic [DATA_W-1:0] NOT_READY_VAL = 8'h00;
   localparam logic [DATA_W-1:0] UNMAPPED_VAL = 8'h00;

   // Pages present in storage: 0..5, 6 and 7 on the quad variant only, 9, a, b
   localparam logic [PAGE_W-1:0] PAGE_LOOP_C = 8'h06;
   localparam logic [PAGE_W-1:0] PAGE_LOOP_D = 8'h07;
   localparam logic [PAGE_W-1:0] PAGE_LAST_LOW = 8'h07;
   localparam logic [PAGE_W-1:0] PAGE_CTRL_IO = 8'h09;
   localparam logic [PAGE_W-1:0] PAGE_DIV_EN = 8'h0a;
   localparam logic [PAGE_W-1:0] PAGE_CLK_DIS = 8'h0b;
   localparam logic [PAGE_W-1:0] PAGE_ALARM = 8'h00;
   localparam logic [PAGE_W-1:0] PAGE_OUTPUT = 8'h01;

   // Storage array: low page nibble and offset form the index
   localparam int MEM_AW = 12;
   localparam int MEM_DEPTH = 3072;
   localparam logic [MEM_AW-1:0] MEM_LAST = 12'hbff;

   // Page 0 special locations
   localparam logic [OFF_W-1:0] STICKY_OFF = 8'h12;
   localparam logic [OFF_W-1:0] BURN_OFF = 8'he3;
   localparam int BURN_BIT = 0;
   localparam logic [OFF_W-1:0] REF_SEL_OFF = 8'h20;
   localparam logic [OFF_W-1:0] IO_LEVEL_OFF = 8'h21;
   // Page 1 output enables, one bit per output clock
   localparam logic [OFF_W-1:0] OUT_EN_OFF = 8'h02;

   // Blank-part defaults
   localparam logic [DATA_W-1:0] REF_SEL_XTAL_48M = 8'h01;
   localparam logic [DATA_W-1:0] IO_LEVEL_1V8 = 8'h00;
   localparam logic [DATA_W-1:0] OUT_EN_BLANK = 8'h00;

   // Strap synchroniser settle count
   localparam logic [MEM_AW-1:0] STRAP_SETTLE = 12'h002;

   // ----------------------------------------------------------------
   // Host controller APB registers
   // ----------------------------------------------------------------
   localparam int APB_AW = 8;
   localparam logic [APB_AW-1:0] A_ADDR = 8'h00;
   localparam logic [APB_AW-1:0] A_DATA = 8'h04;
   localparam logic [APB_AW-1:0] A_CTRL = 8'h08;
   localparam logic [APB_AW-1:0] A_RDATA = 8'h0c;
   localparam logic [APB_AW-1:0] A_STAT = 8'h10;
   localparam logic [APB_AW-1:0] A_MASK = 8'h14;
   localparam int CTRL_GO = 0;
   localparam int CTRL_WRITE = 1;
   localparam int CTRL_RMW = 2;
   localparam int CTRL_BUSY = 8;
   localparam int STAT_W = 2;
   localparam int STAT_DONE = 0;
   localparam int STAT_ERR = 1;

   typedef enum logic [1:0] {
      D_STRAP = 2'b00,
      D_INIT = 2'b01,
      D_RUN = 2'b10,
      D_BURN = 2'b11
   } dev_state_t;

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_PAGE = 3'b001,
      H_READ = 3'b010,
      H_WRITE = 3'b011
   } host_state_t;

   // Page holds storage at all
   function automatic logic page_present(input logic [PAGE_W-1:0] p,
                                         input logic quad);
      logic r;
      r = 1'b0;
      if (p <= PAGE_LAST_LOW) begin
         r = quad || (p != PAGE_LOOP_C && p != PAGE_LOOP_D);
      end else if (p == PAGE_CTRL_IO || p == PAGE_DIV_EN ||
                   p == PAGE_CLK_DIS) begin
         r = 1'b1;
      end
      return r;
   endfunction

endpackage

// >>> design/regbank_if.sv
// Byte-access link between host controller and paged register bank
`timescale 1ns/1ps
interface regbank_if;
   logic req;
   logic we;
   logic [7:0] offset;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;

   modport dev (input req, input we, input offset, input wdata,
                output ack, output rdata);
   modport host (output req, output we, output offset, output wdata,
                 input ack, input rdata);
endinterface

// >>> design/regbank_device.sv
// Paged register bank: page select, readiness, sticky flags, burn
`timescale 1ns/1ps
// Behaviour
// RULE1: every location holds one byte
// RULE2: pages of up to 256 byte addresses
// RULE3: offset 0x01 write loads page selection
// RULE4: page selection persists until rewritten
// RULE5: address is page high byte, offset low
// RULE6: readiness readable at 0xFE on any page
// RULE7: host changes fields by read-modify-write
// RULE8: host avoids undocumented pages and bits
// RULE9: fixed page-to-function map, quad variant pages
// RULE10: self-clearing bit clears when operation ends
// RULE11: sticky flags set by events, clear on zero
// RULE12: blank part powers up outputs disabled
// RULE13: blank defaults: 48 MHz crystal, 1.8 V
// RULE14: preprogrammed part loads from nonvolatile store
// RULE15: volatile writes accepted at any time; link requests are taken only in run and burn, not during strap or load
// RULE16: burn copies registers into nonvolatile store
// RULE17: reading page select returns current page
// RULE18: page selection resets to zero
// RULE19: unimplemented addresses ignore writes, read zero
module regbank_device
   import regmap_pkg::*;
#(
   parameter logic QUAD_VARIANT = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   regbank_if.dev link,
   input wire logic [7:0] event_in,
   input wire logic preprogrammed,
   output logic [7:0] clock_out_enable,
   output logic [7:0] ref_select,
   output logic [7:0] io_level,
   output logic device_ready
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] cfg_mem [0:MEM_DEPTH-1]; // RULE1
   logic [DATA_W-1:0] nonvolatile_store [0:MEM_DEPTH-1];

   dev_state_t state_q;
   dev_state_t state_d;
   logic [MEM_AW-1:0] walk_q;
   logic [MEM_AW-1:0] walk_d;
   logic [PAGE_W-1:0] page_q;
   logic [DATA_W-1:0] input0_signal_loss_sticky_q;
   logic [DATA_W-1:0] sticky_d;
   logic burn_busy_q;
   logic strap_s1_q;
   logic strap_s2_q;
   logic strap_q;
   logic ack_q;
   logic [DATA_W-1:0] rdata_q;
   logic [7:0] out_en_q;
   logic [7:0] ref_sel_q;
   logic [7:0] io_level_q;
   logic ready_q;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire running = (state_q == D_RUN) || (state_q == D_BURN);
   wire take = running && link.req && !ack_q; // RULE15
   wire [ADDR_W-1:0] full_addr = {page_q, link.offset}; // RULE5
   wire off_is_page = link.offset == PAGE_SEL_OFF;
   wire off_is_ready = link.offset == READY_OFF; // RULE6
   wire page_ok = page_present(page_q, QUAD_VARIANT); // RULE9
   wire is_sticky = page_q == PAGE_ALARM && link.offset == STICKY_OFF;
   wire is_burn = page_q == PAGE_ALARM && link.offset == BURN_OFF;
   wire is_special = off_is_page || off_is_ready || is_sticky || is_burn;
   wire is_store = page_ok && !is_special; // RULE2
   wire [MEM_AW-1:0] link_idx = {full_addr[11:8], full_addr[7:0]};
   wire wr_take = take && link.we;
   wire burn_start = wr_take && is_burn && link.wdata[BURN_BIT] &&
                     state_q == D_RUN;
   wire walk_end = walk_q == MEM_LAST;

   // ----------------------------------------------------------------
   // Blank-part default contents
   // ----------------------------------------------------------------
   function automatic logic [DATA_W-1:0] blank_default(
      input logic [MEM_AW-1:0] idx);
      logic [DATA_W-1:0] v;
      v = 8'h00;
      if (idx == {PAGE_ALARM[3:0], REF_SEL_OFF}) begin
         v = REF_SEL_XTAL_48M; // RULE13
      end else if (idx == {PAGE_ALARM[3:0], IO_LEVEL_OFF}) begin
         v = IO_LEVEL_1V8; // RULE13
      end else if (idx == {PAGE_OUTPUT[3:0], OUT_EN_OFF}) begin
         v = OUT_EN_BLANK; // RULE12
      end
      return v;
   endfunction

   // ----------------------------------------------------------------
   // Single write port into the volatile registers
   // ----------------------------------------------------------------
   wire init_we = state_q == D_INIT;
   wire link_we = wr_take && is_store;
   wire mem_we = init_we || link_we;
   wire [MEM_AW-1:0] mem_idx = init_we ? walk_q : link_idx;
   wire [DATA_W-1:0] init_val = strap_q ? nonvolatile_store[walk_q] :
                                blank_default(walk_q); // RULE14
   wire [DATA_W-1:0] mem_wdata = init_we ? init_val : link.wdata;

   always_ff @(posedge pclk) begin
      if (mem_we) begin
         cfg_mem[mem_idx] <= mem_wdata;
      end
   end

   // Copy runs one location per cycle at the walk counter
   always_ff @(posedge pclk) begin
      if (state_q == D_BURN) begin
         nonvolatile_store[walk_q] <= cfg_mem[walk_q]; // RULE16
      end
   end

   // ----------------------------------------------------------------
   // Read selection
   // ----------------------------------------------------------------
   wire [DATA_W-1:0] ready_byte = ready_q ? READY_VAL : NOT_READY_VAL;
   wire [DATA_W-1:0] burn_byte = {{(DATA_W-1){1'b0}}, burn_busy_q};
   wire [DATA_W-1:0] rd_value =
      off_is_page ? page_q : // RULE17
      off_is_ready ? ready_byte : // RULE6
      !page_ok ? UNMAPPED_VAL : // RULE19
      is_sticky ? input0_signal_loss_sticky_q :
      is_burn ? burn_byte :
      cfg_mem[link_idx];

   // ----------------------------------------------------------------
   // Sequencer: strap capture, load, run, burn
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      walk_d = walk_q;
      case (state_q)
         D_STRAP: begin
            walk_d = walk_q + 12'h001;
            if (walk_q == STRAP_SETTLE) begin
               state_d = D_INIT;
               walk_d = '0;
            end
         end
         D_INIT: begin
            walk_d = walk_q + 12'h001;
            if (walk_end) begin
               state_d = D_RUN;
               walk_d = '0;
            end
         end
         D_RUN: begin
            if (burn_start) begin
               state_d = D_BURN;
               walk_d = '0;
            end
         end
         D_BURN: begin
            walk_d = walk_q + 12'h001;
            if (walk_end) begin
               state_d = D_RUN;
               walk_d = '0;
            end
         end
         default: begin
            state_d = D_STRAP;
            walk_d = '0;
         end
      endcase
   end

   // Set wins over a clearing write in the same cycle
   always_comb begin
      sticky_d = input0_signal_loss_sticky_q;
      if (wr_take && is_sticky) begin
         sticky_d = input0_signal_loss_sticky_q & link.wdata; // RULE11
      end
      sticky_d = sticky_d | event_in; // RULE11
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_s1_q <= 1'b0;
         strap_s2_q <= 1'b0;
      end else begin
         strap_s1_q <= preprogrammed;
         strap_s2_q <= strap_s1_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= D_STRAP;
         walk_q <= '0;
         strap_q <= 1'b0;
         ready_q <= 1'b0;
      end else begin
         state_q <= state_d;
         walk_q <= walk_d;
         if (state_q == D_STRAP) begin
            strap_q <= strap_s2_q;
         end
         ready_q <= state_d == D_RUN || state_d == D_BURN;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         page_q <= PAGE_RESET; // RULE18
      end else if (wr_take && off_is_page) begin
         page_q <= link.wdata; // RULE3 RULE4
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input0_signal_loss_sticky_q <= '0;
         burn_busy_q <= 1'b0;
      end else begin
         input0_signal_loss_sticky_q <= sticky_d;
         burn_busy_q <= state_d == D_BURN; // RULE10
      end
   end

   // ----------------------------------------------------------------
   // Link answer
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         ack_q <= take;
         if (take) begin
            rdata_q <= link.we ? '0 : rd_value;
         end
      end
   end

   // ----------------------------------------------------------------
   // Mirrors of configuration bytes driving the device's own pins
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_en_q <= OUT_EN_BLANK; // RULE12
         ref_sel_q <= REF_SEL_XTAL_48M;
         io_level_q <= IO_LEVEL_1V8;
      end else if (mem_we) begin
         if (mem_idx == {PAGE_OUTPUT[3:0], OUT_EN_OFF}) begin
            out_en_q <= mem_wdata;
         end
         if (mem_idx == {PAGE_ALARM[3:0], REF_SEL_OFF}) begin
            ref_sel_q <= mem_wdata;
         end
         if (mem_idx == {PAGE_ALARM[3:0], IO_LEVEL_OFF}) begin
            io_level_q <= mem_wdata;
         end
      end
   end

   assign link.ack = ack_q;
   assign link.rdata = rdata_q;
   assign clock_out_enable = out_en_q;
   assign ref_select = ref_sel_q;
   assign io_level = io_level_q;
   assign device_ready = ready_q;

endmodule

// >>> design/regbank_host.sv
// Host controller: APB command registers driving the paged bank link
`timescale 1ns/1ps
module regbank_host
   import regmap_pkg::*;
#(
   parameter logic QUAD_VARIANT = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   regbank_if.host link
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [DATA_W-1:0] mask_q;
   logic write_q;
   logic rmw_q;
   logic [DATA_W-1:0] rdata_q;
   logic [STAT_W-1:0] status_q;
   logic [STAT_W-1:0] status_d;
   logic [STAT_W-1:0] irq_mask_q;
   logic [PAGE_W-1:0] cached_page_q;
   logic page_known_q;
   host_state_t state_q;
   logic req_q;
   logic we_q;
   logic [OFF_W-1:0] off_q;
   logic [DATA_W-1:0] lwdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic irq_q;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire access = psel && penable && pready_q;
   wire wr = access && pwrite;
   wire busy = state_q != H_IDLE;
   wire hit = paddr == A_ADDR || paddr == A_DATA || paddr == A_CTRL ||
              paddr == A_RDATA || paddr == A_STAT || paddr == A_MASK;
   wire go = wr && paddr == A_CTRL && pwdata[CTRL_GO] && !busy;
   wire [PAGE_W-1:0] tgt_page = addr_q[15:8]; // RULE5
   wire [OFF_W-1:0] tgt_off = addr_q[7:0];
   wire page_legal = page_present(tgt_page, QUAD_VARIANT); // RULE8
   wire page_hit = page_known_q && cached_page_q == tgt_page; // RULE4
   wire ack = req_q && link.ack;
   wire [DATA_W-1:0] merged = (link.rdata & ~mask_q) |
                              (wdata_q & mask_q); // RULE7
   wire set_err = go && !page_legal;
   wire finish_rd = ack && state_q == H_READ && !rmw_q;
   wire finish_wr = ack && state_q == H_WRITE;
   wire [STAT_W-1:0] set_bits = {set_err, finish_rd || finish_wr};
   wire [STAT_W-1:0] clr_bits = (wr && paddr == A_STAT) ?
                                pwdata[STAT_W-1:0] : '0;
   wire [31:0] rd_mux =
      paddr == A_ADDR ? {16'h0000, addr_q} :
      paddr == A_DATA ? {16'h0000, mask_q, wdata_q} :
      paddr == A_CTRL ? {23'h000000, busy, 5'h00, rmw_q, write_q, 1'b0} :
      paddr == A_RDATA ? {24'h000000, rdata_q} :
      paddr == A_STAT ? {30'h00000000, status_q} :
      paddr == A_MASK ? {30'h00000000, irq_mask_q} : 32'h00000000;

   // Set wins over a write-one clear in the same cycle
   always_comb begin
      status_d = (status_q & ~clr_bits) | set_bits;
   end

   // ----------------------------------------------------------------
   // APB slave: one wait state, answer from flops
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= psel && penable && !pready_q;
         pslverr_q <= psel && penable && !pready_q && !hit;
         if (psel && penable && !pready_q) begin
            prdata_q <= rd_mux;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_q <= '0;
         wdata_q <= '0;
         mask_q <= '0;
         irq_mask_q <= '0;
         write_q <= 1'b0;
         rmw_q <= 1'b0;
         status_q <= '0;
         irq_q <= 1'b0;
      end else begin
         if (wr && paddr == A_ADDR && !busy) begin
            addr_q <= pwdata[ADDR_W-1:0];
         end
         if (wr && paddr == A_DATA && !busy) begin
            wdata_q <= pwdata[7:0];
            mask_q <= pwdata[15:8];
         end
         if (wr && paddr == A_MASK) begin
            irq_mask_q <= pwdata[STAT_W-1:0];
         end
         if (go) begin
            write_q <= pwdata[CTRL_WRITE];
            rmw_q <= pwdata[CTRL_RMW];
         end
         status_q <= status_d;
         irq_q <= |(status_d & irq_mask_q);
      end
   end

   // ----------------------------------------------------------------
   // Link sequencer: optional page write, then read and/or write
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= H_IDLE;
         req_q <= 1'b0;
         we_q <= 1'b0;
         off_q <= '0;
         lwdata_q <= '0;
         rdata_q <= '0;
         cached_page_q <= PAGE_RESET;
         page_known_q <= 1'b0;
      end else begin
         case (state_q)
            H_IDLE: begin
               if (go && page_legal) begin
                  req_q <= 1'b1;
                  if (!page_hit) begin
                     state_q <= H_PAGE; // RULE3
                     we_q <= 1'b1;
                     off_q <= PAGE_SEL_OFF;
                     lwdata_q <= tgt_page;
                  end else if (pwdata[CTRL_WRITE] && !pwdata[CTRL_RMW]) begin
                     state_q <= H_WRITE;
                     we_q <= 1'b1;
                     off_q <= tgt_off;
                     lwdata_q <= wdata_q;
                  end else begin
                     state_q <= H_READ;
                     we_q <= 1'b0;
                     off_q <= tgt_off;
                  end
               end
            end
            H_PAGE: begin
               if (ack) begin
                  cached_page_q <= tgt_page;
                  page_known_q <= 1'b1;
                  off_q <= tgt_off;
                  if (write_q && !rmw_q) begin
                     state_q <= H_WRITE;
                     lwdata_q <= wdata_q;
                  end else begin
                     state_q <= H_READ;
                     we_q <= 1'b0;
                  end
               end
            end
            H_READ: begin
               if (ack) begin
                  rdata_q <= link.rdata;
                  if (rmw_q) begin
                     state_q <= H_WRITE; // RULE7
                     we_q <= 1'b1;
                     lwdata_q <= merged;
                  end else begin
                     state_q <= H_IDLE;
                     req_q <= 1'b0;
                  end
               end
            end
            H_WRITE: begin
               if (ack) begin
                  state_q <= H_IDLE;
                  req_q <= 1'b0;
                  we_q <= 1'b0;
                  if (off_q == PAGE_SEL_OFF) begin
                     cached_page_q <= lwdata_q;
                  end
               end
            end
            default: begin
               state_q <= H_IDLE;
               req_q <= 1'b0;
            end
         endcase
      end
   end

   assign link.req = req_q;
   assign link.we = we_q;
   assign link.offset = off_q;
   assign link.wdata = lwdata_q;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;

endmodule

// >>> dv/regbank_link_checker.sv
// Link protocol assertions between host controller and paged bank
`timescale 1ns/1ps
module regbank_link_checker
   import regmap_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic req,
   input wire logic we,
   input wire logic [7:0] offset,
   input wire logic [7:0] wdata,
   input wire logic ack,
   input wire logic [7:0] rdata
);
   logic [7:0] page_q;
   logic seen_q;
   wire page_wr = ack && we && offset == PAGE_SEL_OFF;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         page_q <= PAGE_RESET;
         seen_q <= 1'b0;
      end else begin
         if (page_wr) begin
            page_q <= wdata;
         end
         seen_q <= seen_q || ack;
      end
   end
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence read_at(logic [7:0] o);
      ack && !we && offset == o;
   endsequence
   sequence fresh_req;
      req && !ack && !$past(ack);
   endsequence
   ack_pulse_a: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property ($rose(ack) |-> $past(req))
      else $error("ack without request");
   ready_read_a: assert property (
      read_at(READY_OFF) |-> rdata == READY_VAL)
      else $error("wrong readiness value");
   page_read_a: assert property (
      read_at(PAGE_SEL_OFF) |-> rdata == page_q)
      else $error("page read differs from last page write");
   req_hold_a: assert property (
      req && !ack |=> req && $stable(offset) && $stable(we) && $stable(wdata))
      else $error("request changed before ack");
   rdata_keep_a: assert property (ack |=> $stable(rdata))
      else $error("read byte not held");
   req_release_a: assert property ($fell(req) |-> $past(ack))
      else $error("request dropped without ack");
   answer_time_a: assert property (
      (seen_q and fresh_req) |-> ##1 ack)
      else $error("ready device did not answer");
endmodule

// >>> dv/paged_register_map_access_tb_top.sv
// Bench: APB host controller driving the paged register bank
`timescale 1ns/1ps
module paged_register_map_access_tb_top
   import regmap_pkg::*;
();
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, preprogrammed = 1'b0, pready, pslverr, irq, err_q;
   logic device_ready;
   logic [7:0] paddr = 8'h00, event_in = 8'h00;
   logic [7:0] clock_out_enable, ref_select, io_level;
   logic [31:0] pwdata = 32'h0, prdata, rd, rnd = 32'h00018066;
   logic [15:0] a;
   logic [7:0] mdl [int];
   localparam logic [7:0] PG [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
      8'h05, 8'h06, 8'h07, 8'h09, 8'h0a, 8'h0b};
   int error_cnt = 0, check_count = 0, cyc = 0;
   regbank_if lk();
   regbank_host u_regbank_host (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .link(lk.host));
   regbank_device u_regbank_device (.pclk, .presetn, .link(lk.dev),
      .event_in, .preprogrammed, .clock_out_enable, .ref_select, .io_level,
      .device_ready);
   regbank_link_checker u_regbank_link_checker (.pclk, .presetn,
      .req(lk.req), .we(lk.we), .offset(lk.offset), .wdata(lk.wdata),
      .ack(lk.ack), .rdata(lk.rdata));
   // ---------------------------------------------------------------
   // Bus tasks
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (error_cnt == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] ad,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Bank access through the controller; c is {rmw, write, go}
   task automatic op(input logic [15:0] ad, input logic [15:0] d,
                     input logic [2:0] c);
      apb(1'b1, A_ADDR, {16'h0000, ad});
      apb(1'b1, A_DATA, {16'h0000, d});
      apb(1'b1, A_CTRL, {29'h0, c});
      do apb(1'b0, A_CTRL, 32'h0); while (rd[CTRL_BUSY] !== 1'b0);
      apb(1'b0, A_RDATA, 32'h0);
   endtask
   task automatic readback();
      foreach (mdl[k]) begin
         op(k[15:0], 16'h0000, 3'b001);
         chk(rd[7:0], mdl[k]);
      end
   endtask
   task automatic do_reset();
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      do @(posedge pclk); while (device_ready !== 1'b1);
   endtask
   initial forever #2 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         give_verdict();
      end
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      do_reset();
      chk(clock_out_enable, OUT_EN_BLANK);
      chk(ref_select, REF_SEL_XTAL_48M);
      chk(io_level, IO_LEVEL_1V8);
      foreach (PG[i]) begin
         rnd = lfsr(rnd);
         a = {PG[i], 2'b01, rnd[5:1], 1'b0};
         mdl[a] = rnd[15:8];
         op(a, {8'h00, rnd[15:8]}, 3'b011);
      end
      op(16'h0280, 16'h00a5, 3'b011);
      op(16'h0280, 16'h3c0f, 3'b111);
      mdl[16'h0280] = (8'ha5 & ~8'h3c) | (8'h0f & 8'h3c);
      op(16'h0102, 16'h005a, 3'b011);
      mdl[16'h0102] = 8'h5a;
      chk(clock_out_enable, 32'h5a);
      readback();
      op(16'h0401, 16'h0000, 3'b001);
      chk(rd[7:0], 8'h04);
      op(16'h03fe, 16'h0000, 3'b001);
      chk(rd[7:0], READY_VAL);
      op(16'h0c40, 16'h0011, 3'b011);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd[STAT_ERR], 1'b1);
      apb(1'b0, 8'hf0, 32'h0);
      chk(err_q, 1'b1);
      apb(1'b1, A_STAT, 32'h3);
      apb(1'b1, A_MASK, 32'h1);
      event_in <= 8'h28;
      op(16'h0012, 16'h0000, 3'b001);
      event_in <= 8'h00;
      chk(rd[7:0], 8'h28);
      chk(irq, 1'b1);
      op(16'h0012, 16'h00f7, 3'b011);
      op(16'h0012, 16'h0000, 3'b001);
      chk(rd[7:0], 8'h20);
      apb(1'b1, A_MASK, 32'h0);
      apb(1'b1, A_STAT, 32'h3);
      apb(1'b0, A_STAT, 32'h0);
      chk(rd, 32'h0);
      chk(irq, 1'b0);
      op(16'h00e3, 16'h0001, 3'b011);
      op(16'h00e3, 16'h0000, 3'b001);
      chk(rd[0], 1'b1);
      repeat (3072) @(posedge pclk);
      op(16'h00e3, 16'h0000, 3'b001);
      chk(rd[0], 1'b0);
      preprogrammed <= 1'b1;
      do_reset();
      readback();
      chk(clock_out_enable, 32'h5a);
      give_verdict();
   end
endmodule
